/* ifr_pkg.sv */
package ifr_pkg;

  // ----------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------
  localparam int IFR_ADDR_W = 8;
  localparam int IFR_DW = 32;
  localparam int IFR_CMD_W = 7;

  // ----------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------
  localparam logic [7:0] IFR_OFF_CTRL = 8'h00;
  localparam logic [7:0] IFR_OFF_ADDR = 8'h04;
  localparam logic [7:0] IFR_OFF_DATA = 8'h08;
  localparam logic [7:0] IFR_OFF_CMD = 8'h0C;
  localparam logic [7:0] IFR_OFF_TRG = 8'h10;
  localparam logic [7:0] IFR_OFF_BASE = 8'h14;

  // ----------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------
  localparam int IFR_BIT_EN = 0;
  localparam int IFR_BIT_BOOT = 1;
  localparam int IFR_BIT_SPU = 2;
  localparam int IFR_BIT_APU = 3;
  localparam int IFR_BIT_CFGU = 4;
  localparam int IFR_BIT_GO = 0;
  localparam int IFR_CFG0_BOOT_BIT = 7;

  // ----------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------
  localparam logic [31:0] IFR_RST_WORD = 32'h0000_0000;
  localparam logic [6:0] IFR_RST_CMD = 7'h00;
  localparam logic IFR_RST_BIT = 1'b0;

  // ----------------------------------------------------------
  // Start sequencer states
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    IFR_IDLE,
    IFR_START,
    IFR_BUSY
  } ifr_trg_state_t;

endpackage

/* ifr_start_ctl.sv */
`timescale 1ns/100ps
module ifr_start_ctl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Request and completion
  input wire logic go_req,
  input wire logic op_done,
  // Status
  output logic busy,
  output logic op_start
);
  import ifr_pkg::*;

  typedef struct packed {
    ifr_trg_state_t st;
    logic busy;
    logic start;
  } ifr_start_state_t;

  ifr_start_state_t s_q;
  ifr_start_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    unique case (s_q.st)
      IFR_IDLE: begin
        if (go_req) begin
          s_d.st = IFR_START;
          s_d.start = 1'b1;
        end
      end
      IFR_START: begin
        s_d.st = IFR_BUSY;
      end
      IFR_BUSY: begin
        // A new request in the done cycle wins over the clear
        if (go_req) begin
          s_d.st = IFR_START;
          s_d.start = 1'b1;
        end else if (op_done) begin
          s_d.st = IFR_IDLE;
        end
      end
      default: s_d.st = IFR_IDLE;
    endcase
    s_d.busy = (s_d.st != IFR_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.st <= IFR_IDLE;
      s_q.busy <= IFR_RST_BIT;
      s_q.start <= IFR_RST_BIT;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign op_start = s_q.start;

endmodule

/* ifr_regs.sv */
// Behaviour
// - Bit 1 of the control register selects the next boot source, 1 loader and 0 application.
// - Outside a processor-only or system reset, boot select loads the inverse of config word zero bit 7.
// - Reading boot select reports the region the chip booted from, 1 loader and 0 application; here a read returns bit 1 as loaded at startup or last written.
// - Control bit 2 blocks secure-region updates when 0 and allows them when 1.
// - Control bit 3 allows application-region self-updates when 1.
// - Control bit 4 forbids configuration updates when 0 and permits them when 1.
// - Control bit 0 enables the programming function.
// - Enable, boot select and update-enable bits change only while the register unlock is active.
// - Offset 0x04 holds a 32-bit read/write target address that resets to zero.
// - Offset 0x08 holds a 32-bit read/write data word that resets to zero.
// - Offset 0x0C holds a 7-bit command code in bits 6..0, upper bits reserved, reset zero.
// - Setting the protected bit 0 at offset 0x10 starts the programmed operation.
// - Offset 0x14 is a read-only data-region base loaded from startup configuration.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module ifr_regs #(
  parameter int ADDR_W = ifr_pkg::IFR_ADDR_W
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [ifr_pkg::IFR_DW-1:0] pwdata,
  output logic [ifr_pkg::IFR_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // System and startup configuration
  input wire logic reg_unlock,
  input wire logic reset_kept_boot,
  input wire logic boot_select_retained,
  input wire logic [ifr_pkg::IFR_DW-1:0] config_word_zero,
  input wire logic [ifr_pkg::IFR_DW-1:0] data_region_cfg,
  // Flash sequencer side
  input wire logic op_done,
  input wire logic op_data_we,
  input wire logic [ifr_pkg::IFR_DW-1:0] op_rdata,
  output logic op_start,
  output logic start_trigger,
  output logic prog_function_enable,
  output logic boot_select,
  output logic secure_region_update_en,
  output logic app_region_update_en,
  output logic config_update_en,
  output logic [ifr_pkg::IFR_DW-1:0] target_address,
  output logic [ifr_pkg::IFR_DW-1:0] data_word,
  output logic [ifr_pkg::IFR_CMD_W-1:0] command_code,
  output logic [ifr_pkg::IFR_DW-1:0] data_region_base
);
  import ifr_pkg::*;

  // ----------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_aw
    $error("ADDR_W must cover offsets 0x00..0x14 and stay within 32 bits");
  end

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  typedef struct packed {
    logic en;
    logic boot;
    logic spu;
    logic apu;
    logic cfgu;
    logic loaded;
    logic [IFR_DW-1:0] addr;
    logic [IFR_DW-1:0] data;
    logic [IFR_CMD_W-1:0] cmd;
    logic [IFR_DW-1:0] base;
    logic ready;
    logic slverr;
    logic [IFR_DW-1:0] rdata;
  } ifr_regs_state_t;

  ifr_regs_state_t s_q;
  ifr_regs_state_t s_d;

  logic busy;
  logic go_req;
  logic setup;
  logic acc_wr;
  logic hit_ctrl;
  logic hit_addr;
  logic hit_data;
  logic hit_cmd;
  logic hit_trg;
  logic hit_base;

  // ----------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------
  assign hit_ctrl = (paddr == ADDR_W'(IFR_OFF_CTRL));
  assign hit_addr = (paddr == ADDR_W'(IFR_OFF_ADDR));
  assign hit_data = (paddr == ADDR_W'(IFR_OFF_DATA));
  assign hit_cmd = (paddr == ADDR_W'(IFR_OFF_CMD));
  assign hit_trg = (paddr == ADDR_W'(IFR_OFF_TRG));
  assign hit_base = (paddr == ADDR_W'(IFR_OFF_BASE));

  assign setup = psel && !penable;
  // Writes land only on the edge that completes the access
  assign acc_wr = psel && penable && s_q.ready && pwrite;

  // Start needs unlock, the enable bit and an idle sequencer
  assign go_req = acc_wr && hit_trg && reg_unlock && pwdata[IFR_BIT_GO]
                  && s_q.en && !busy;

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ready = setup;
    s_d.slverr = 1'b0;
    if (setup) begin
      s_d.slverr = !(hit_ctrl || hit_addr || hit_data || hit_cmd || hit_trg || hit_base);
      s_d.rdata = IFR_RST_WORD;
      if (hit_ctrl) begin
        s_d.rdata[IFR_BIT_EN] = s_q.en;
        s_d.rdata[IFR_BIT_BOOT] = s_q.boot;
        s_d.rdata[IFR_BIT_SPU] = s_q.spu;
        s_d.rdata[IFR_BIT_APU] = s_q.apu;
        s_d.rdata[IFR_BIT_CFGU] = s_q.cfgu;
      end else if (hit_addr) begin
        s_d.rdata = s_q.addr;
      end else if (hit_data) begin
        s_d.rdata = s_q.data;
      end else if (hit_cmd) begin
        s_d.rdata[IFR_CMD_W-1:0] = s_q.cmd;
      end else if (hit_trg) begin
        s_d.rdata[IFR_BIT_GO] = busy;
      end else if (hit_base) begin
        s_d.rdata = s_q.base;
      end
    end

    // Protected control bits
    if (acc_wr && hit_ctrl && reg_unlock) begin
      s_d.en = pwdata[IFR_BIT_EN];
      s_d.boot = pwdata[IFR_BIT_BOOT];
      s_d.spu = pwdata[IFR_BIT_SPU];
      s_d.apu = pwdata[IFR_BIT_APU];
      s_d.cfgu = pwdata[IFR_BIT_CFGU];
    end

    // Operands freeze while an operation runs
    if (acc_wr && !busy) begin
      if (hit_addr) begin
        s_d.addr = pwdata;
      end
      if (hit_data) begin
        s_d.data = pwdata;
      end
      if (hit_cmd) begin
        s_d.cmd = pwdata[IFR_CMD_W-1:0];
      end
    end

    // Word returned by a finished operation
    if (busy && op_done && op_data_we) begin
      s_d.data = op_rdata;
    end

    // First enabled cycle after reset release wins over any write
    if (!s_q.loaded) begin
      s_d.loaded = 1'b1;
      s_d.boot = reset_kept_boot ? boot_select_retained
                                 : !config_word_zero[IFR_CFG0_BOOT_BIT];
      s_d.base = data_region_cfg;
    end
  end

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.en <= IFR_RST_BIT;
      s_q.boot <= IFR_RST_BIT;
      s_q.spu <= IFR_RST_BIT;
      s_q.apu <= IFR_RST_BIT;
      s_q.cfgu <= IFR_RST_BIT;
      s_q.loaded <= IFR_RST_BIT;
      s_q.addr <= IFR_RST_WORD;
      s_q.data <= IFR_RST_WORD;
      s_q.cmd <= IFR_RST_CMD;
      s_q.base <= IFR_RST_WORD;
      s_q.ready <= IFR_RST_BIT;
      s_q.slverr <= IFR_RST_BIT;
      s_q.rdata <= IFR_RST_WORD;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------
  // Start sequencer
  // ----------------------------------------------------------
  ifr_start_ctl u_start (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .go_req(go_req),
    .op_done(op_done),
    .busy(busy),
    .op_start(op_start)
  );

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slverr;
  assign start_trigger = busy;
  assign prog_function_enable = s_q.en;
  assign boot_select = s_q.boot;
  assign secure_region_update_en = s_q.spu;
  assign app_region_update_en = s_q.apu;
  assign config_update_en = s_q.cfgu;
  assign target_address = s_q.addr;
  assign data_word = s_q.data;
  assign command_code = s_q.cmd;
  assign data_region_base = s_q.base;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_boot_write;
    acc_wr && hit_ctrl && reg_unlock && clk_en && s_q.loaded
      |=> boot_select == $past(pwdata[IFR_BIT_BOOT]);
  endproperty
  a_boot_write: assert property (p_boot_write) else $error("boot select write lost");

  property p_boot_load;
    clk_en && !s_q.loaded && !reset_kept_boot
      |=> boot_select == !$past(config_word_zero[IFR_CFG0_BOOT_BIT]);
  endproperty
  a_boot_load: assert property (p_boot_load) else $error("boot select not loaded");

  property p_boot_read;
    setup && hit_ctrl && clk_en ##1 psel && penable
      |-> prdata[IFR_BIT_BOOT] == $past(boot_select);
  endproperty
  a_boot_read: assert property (p_boot_read) else $error("boot select read wrong");

  property p_locked;
    acc_wr && hit_ctrl && !reg_unlock && s_q.loaded
      |=> $stable({prog_function_enable, secure_region_update_en,
                   app_region_update_en, config_update_en, boot_select});
  endproperty
  a_locked: assert property (p_locked) else $error("locked bits changed");

  property p_upd_en;
    acc_wr && hit_ctrl && reg_unlock && clk_en
      |=> {config_update_en, app_region_update_en, secure_region_update_en}
          == $past(pwdata[IFR_BIT_CFGU:IFR_BIT_SPU]);
  endproperty
  a_upd_en: assert property (p_upd_en) else $error("update enables wrong");

  property p_addr_wr;
    acc_wr && hit_addr && !busy && clk_en |=> target_address == $past(pwdata);
  endproperty
  a_addr_wr: assert property (p_addr_wr) else $error("target address not written");

  property p_cmd_rsv;
    setup && hit_cmd && clk_en |=> prdata[IFR_DW-1:IFR_CMD_W] == '0;
  endproperty
  a_cmd_rsv: assert property (p_cmd_rsv) else $error("command reserved bits set");

  property p_start;
    go_req && clk_en |=> op_start && start_trigger ##1 !op_start;
  endproperty
  a_start: assert property (p_start) else $error("start not issued once");

  property p_no_start_dis;
    !prog_function_enable && !op_start && !start_trigger && clk_en |=> !op_start;
  endproperty
  a_no_start_dis: assert property (p_no_start_dis) else $error("start while disabled");

  property p_done_clr;
    start_trigger && !op_start && op_done && !go_req && clk_en |=> !start_trigger;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("trigger not cleared");

  property p_base_ro;
    s_q.loaded |=> $stable(data_region_base);
  endproperty
  a_base_ro: assert property (p_base_ro) else $error("data base changed");

  c_start: cover property (go_req ##1 op_start);
  c_done: cover property (start_trigger ##[1:20] !start_trigger);
  c_locked: cover property (acc_wr && hit_ctrl && !reg_unlock);
  c_unmapped: cover property (pready && pslverr);

endmodule

/* isp_flash_command_regs_tb.sv */
`timescale 1ns/100ps
module isp_flash_command_regs_tb;
  import ifr_pkg::*;
  // --------------------------------------------------------
  // Stimulus and observed signals
  // --------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, cfg0 = 32'h0, dcfg = 32'h0, op_rdata = 32'h0;
  logic reg_unlock = 1'b0, reset_kept_boot = 1'b0, boot_ret = 1'b0;
  logic op_done = 1'b0, op_data_we = 1'b0;
  logic [31:0] prdata, target_address, data_word, data_region_base, r, v;
  logic pready, pslverr, op_start, start_trigger, prog_function_enable, boot_select, e;
  logic secure_region_update_en, app_region_update_en, config_update_en;
  logic [6:0] command_code;
  logic [4:0] ctl_o;
  int n_errors = 0;
  int comparisons = 0;
  assign ctl_o = {config_update_en, app_region_update_en, secure_region_update_en,
                  boot_select, prog_function_enable};
  always #2 pclk = ~pclk;

  ifr_regs i_ifr_regs (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .reg_unlock, .reset_kept_boot, .boot_select_retained(boot_ret),
    .config_word_zero(cfg0), .data_region_cfg(dcfg), .op_done, .op_data_we, .op_rdata,
    .op_start, .start_trigger, .prog_function_enable, .boot_select, .secure_region_update_en,
    .app_region_update_en, .config_update_en, .target_address, .data_word, .command_code,
    .data_region_base);

  // --------------------------------------------------------
  // Helpers
  // --------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Holds the request until pready is seen; one idle edge after keeps drives apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, r);
    chk({nm, " slverr"}, 32'h0, {31'h0, e});
  endtask

  task automatic rst(input logic kept, input logic ret);
    presetn <= 1'b0;
    reset_kept_boot <= kept;
    boot_ret <= ret;
    cfg0 <= $urandom | {24'h0, kept, 7'h0};
    dcfg <= $urandom;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  function automatic logic [31:0] fld(input logic [7:0] a, input logic [31:0] d);
    return (a == IFR_OFF_CMD) ? {25'h0, d[6:0]} : d;
  endfunction

  function automatic logic [31:0] port_of(input logic [7:0] a);
    return (a == IFR_OFF_ADDR) ? target_address :
           (a == IFR_OFF_DATA) ? data_word : {25'h0, command_code};
  endfunction

  initial begin
    repeat (4000) @(posedge pclk);
    n_errors++;
    end_sim();
  end

  // --------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------
  initial begin
    logic [7:0] a;
    v = $urandom(32'h33FA);
    rst(1'b0, 1'b0);
    chk("boot_select", {31'h0, ~cfg0[7]}, {31'h0, boot_select});
    rd(IFR_OFF_CTRL, {30'h0, ~cfg0[7], 1'b0}, "control");
    rd(IFR_OFF_BASE, dcfg, "base");
    rd(IFR_OFF_ADDR, 32'h0, "address");
    rd(IFR_OFF_DATA, 32'h0, "data");
    rd(IFR_OFF_CMD, 32'h0, "command");
    rd(IFR_OFF_TRG, 32'h0, "trigger");
    apb(1'b1, IFR_OFF_BASE, ~dcfg);
    rd(IFR_OFF_BASE, dcfg, "base after write");
    $display("test reset done");
    v = {30'h0, ~cfg0[7], 1'b0};
    apb(1'b1, IFR_OFF_CTRL, v ^ 32'h1F);
    rd(IFR_OFF_CTRL, v, "locked control");
    reg_unlock <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'h1F : (i == 1) ? 32'h0 : ($urandom & 32'h1F);
      apb(1'b1, IFR_OFF_CTRL, v);
      chk("control bits", v, {27'h0, ctl_o});
      rd(IFR_OFF_CTRL, v, "control");
    end
    $display("test control done");
    for (int k = 0; k < 2; k++) begin
      apb(1'b0, k ? 8'h05 : 8'h18, 32'h0);
      chk("unmapped slverr", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
    end
    for (int i = 0; i < 9; i++) begin
      a = 8'h04 + 8'(4 * (i % 3));
      v = (i < 3) ? 32'hFFFFFFFF : $urandom;
      apb(1'b1, a, v);
      chk("field port", fld(a, v), port_of(a));
      rd(a, fld(a, v), "readback");
    end
    $display("test data registers done");
    apb(1'b1, IFR_OFF_CTRL, 32'h0);
    apb(1'b1, IFR_OFF_TRG, 32'h1);
    chk("trigger while disabled", 32'h0, {31'h0, start_trigger});
    apb(1'b1, IFR_OFF_CTRL, 32'h1);
    reg_unlock <= 1'b0;
    apb(1'b1, IFR_OFF_TRG, 32'h1);
    chk("trigger while locked", 32'h0, {31'h0, start_trigger});
    reg_unlock <= 1'b1;
    apb(1'b1, IFR_OFF_ADDR, 32'hA5A50F0F);
    apb(1'b1, IFR_OFF_TRG, 32'h1);
    chk("start pulse", 32'h1, {31'h0, op_start});
    @(posedge pclk);
    chk("start pulse end", 32'h0, {31'h0, op_start});
    chk("trigger pending", 32'h1, {31'h0, start_trigger});
    apb(1'b1, IFR_OFF_ADDR, 32'h0);
    rd(IFR_OFF_ADDR, 32'hA5A50F0F, "address while busy");
    rd(IFR_OFF_TRG, 32'h1, "trigger busy");
    // Done seen while the enable is low must not clear the trigger
    clk_en <= 1'b0;
    op_done <= 1'b1;
    repeat (2) @(posedge pclk);
    op_done <= 1'b0;
    clk_en <= 1'b1;
    @(posedge pclk);
    chk("trigger frozen", 32'h1, {31'h0, start_trigger});
    v = $urandom;
    op_done <= 1'b1;
    op_data_we <= 1'b1;
    op_rdata <= v;
    @(posedge pclk);
    op_done <= 1'b0;
    op_data_we <= 1'b0;
    @(posedge pclk);
    chk("trigger cleared", 32'h0, {31'h0, start_trigger});
    chk("returned word", v, data_word);
    rd(IFR_OFF_TRG, 32'h0, "trigger idle");
    $display("test trigger done");
    rst(1'b1, 1'b1);
    chk("kept boot_select", 32'h1, {31'h0, boot_select});
    rd(IFR_OFF_ADDR, 32'h0, "address after reset");
    $display("test second reset done");
    end_sim();
  end
endmodule
